/* File: core/mpi_regs.svh */
`ifndef MPI_REGS_SVH
`define MPI_REGS_SVH
// ---------------------------------------------------------------
// Register map
// ---------------------------------------------------------------
`define MPI_TX_LINE_CONFIG_ADDR 16'h1130
`define MPI_TX_PATTERN_SELECT_ADDR 16'h114C
`define MPI_FRAME_POS_ADDR 16'h1150
`define MPI_CFG_RESET 8'h00
`define MPI_PAT_RESET 8'h0C
`define MPI_PAT_WMASK 8'hDF
// Configuration fields
`define MPI_CFG_IDLE_BIT 5
`define MPI_CFG_AIS_BIT 4
`define MPI_CFG_LOS_BIT 3
// Pattern fields
`define MPI_PAT_UNFRAMED_BIT 7
`define MPI_PAT_RELAX_BIT 6
`define MPI_PAT_LOSPOL_BIT 4
`endif

/* File: core/mpi_pkg.sv */
package mpi_pkg;
  // Override currently in force on the outbound stream
  typedef enum logic [2:0] {
    MPI_MODE_DATA,
    MPI_MODE_IDLE,
    MPI_MODE_AIS_FRAMED,
    MPI_MODE_AIS_UNFRAMED,
    MPI_MODE_LOS
  } mpi_mode_type;
  // One outbound bit with its slot class
  typedef struct packed {
    logic valid;
    logic data;
    logic overhead;
    logic cbit;
  } mpi_bit_type;
endpackage : mpi_pkg

/* File: core/mpi_mode_sel.sv */
`timescale 1ns/10ps
`include "mpi_regs.svh"
module mpi_mode_sel
  import mpi_pkg::*;
(
  input wire logic [7:0] cfg,
  input wire logic [7:0] pat,
  output mpi_mode_type mode
);
  // ---------------------------------------------------------------
  // Fixed priority decode
  // ---------------------------------------------------------------
  // fixed priority order
  always_comb begin
    if (cfg[`MPI_CFG_LOS_BIT]) begin
      mode = MPI_MODE_LOS;
    end else if (cfg[`MPI_CFG_AIS_BIT]) begin
      mode = pat[`MPI_PAT_UNFRAMED_BIT] ? MPI_MODE_AIS_UNFRAMED : MPI_MODE_AIS_FRAMED;
    end else if (cfg[`MPI_CFG_IDLE_BIT]) begin
      mode = MPI_MODE_IDLE;
    end else begin
      mode = MPI_MODE_DATA;
    end
  end
endmodule : mpi_mode_sel

/* File: core/mpi_pattern_gen.sv */
`timescale 1ns/10ps
module mpi_pattern_gen (
  input wire logic clk,
  input wire logic rst,
  input wire logic advance,
  input wire logic [3:0] idle_pattern,
  output logic alt_bit,
  output logic idle_bit
);
  logic alt_reg;
  logic [1:0] idle_idx_reg;
  // ---------------------------------------------------------------
  // Payload pattern phases, stepping on payload bits only
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      alt_reg <= 1'b1;
      idle_idx_reg <= 2'h3;
    end else if (advance) begin
      alt_reg <= ~alt_reg;
      idle_idx_reg <= idle_idx_reg - 2'h1;
    end
  end
  assign alt_bit = alt_reg;
  assign idle_bit = idle_pattern[idle_idx_reg];
endmodule : mpi_pattern_gen

/* File: core/mpi_insert.sv */
// Decided for this implementation: register access over APB.
`timescale 1ns/10ps
`include "mpi_regs.svh"
// Contract
// - Signal loss select zero sends all zeros.
// - Signal loss select one sends all ones.
// - Signal loss command replaces every payload and overhead bit.
// - Signal loss command beats every other configuration bit.
// - Strict alarm: framed alternating payload, valid M/F/P, C-bits zero.
// - Relaxed alarm: same framing, C-bits passed through.
// - Relax select zero forces C-bits zero during framed alarm.
// - Relax select one sends relaxed framed alarm.
// - Alarm command bit starts and stops alarm transmission.
// - Alarm command ignored while signal loss command set.
// - Unframed select one sends unframed all ones alarm.
// - Idle command ignored while loss or alarm command set.
module mpi_insert
  import mpi_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic [15:0] PADDR,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire mpi_bit_type IN_BIT,
  output mpi_bit_type OUT_BIT,
  output logic [2:0] MODE
);
  logic [7:0] cfg_reg;
  logic [7:0] pat_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  mpi_bit_type out_reg;
  mpi_bit_type out_next;
  logic [2:0] mode_reg;
  logic [15:0] pos_reg;
  mpi_mode_type mode;
  logic alt_bit;
  logic idle_bit;
  logic advance;
  logic setup;
  logic known;

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  function automatic logic addr_known(input logic [15:0] a);
    addr_known = (a == `MPI_TX_LINE_CONFIG_ADDR) || (a == `MPI_TX_PATTERN_SELECT_ADDR)
      || (a == `MPI_FRAME_POS_ADDR);
  endfunction : addr_known

  assign setup = PSEL && !PENABLE;
  assign known = addr_known(PADDR);

  // No wait state: answer in the access cycle
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= setup;
      pslverr_reg <= setup && !known;
    end
  end

  // Read data captured in setup
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup && !PWRITE) begin
      case (PADDR)
        `MPI_TX_LINE_CONFIG_ADDR: prdata_reg <= {24'h000000, cfg_reg};
        `MPI_TX_PATTERN_SELECT_ADDR: prdata_reg <= {24'h000000, pat_reg};
        `MPI_FRAME_POS_ADDR: prdata_reg <= {13'h0000, mode_reg, pos_reg};
        default: prdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      cfg_reg <= `MPI_CFG_RESET;
      pat_reg <= `MPI_PAT_RESET;
    end else if (PSEL && PENABLE && pready_reg && PWRITE && PSTRB[0]) begin
      if (PADDR == `MPI_TX_LINE_CONFIG_ADDR) begin
        cfg_reg <= PWDATA[7:0];
      end
      if (PADDR == `MPI_TX_PATTERN_SELECT_ADDR) begin
        pat_reg <= PWDATA[7:0] & `MPI_PAT_WMASK;
      end
    end
  end

  // ---------------------------------------------------------------
  // Pattern override
  // ---------------------------------------------------------------
  mpi_mode_sel u_mode_sel (
    .cfg(cfg_reg),
    .pat(pat_reg),
    .mode(mode)
  );

  assign advance = IN_BIT.valid && !IN_BIT.overhead;

  mpi_pattern_gen u_pattern_gen (
    .clk(CORE_CLK),
    .rst(RST),
    .advance(advance),
    .idle_pattern(pat_reg[3:0]),
    .alt_bit(alt_bit),
    .idle_bit(idle_bit)
  );

  always_comb begin
    out_next = IN_BIT;
    case (mode)
      MPI_MODE_LOS: begin
        out_next.data = pat_reg[`MPI_PAT_LOSPOL_BIT];
      end
      MPI_MODE_AIS_UNFRAMED: begin
        out_next.data = 1'b1;
      end
      MPI_MODE_AIS_FRAMED: begin
        if (!IN_BIT.overhead) begin
          out_next.data = alt_bit;
        end else if (IN_BIT.cbit && !pat_reg[`MPI_PAT_RELAX_BIT]) begin
          out_next.data = 1'b0;
        end
      end
      MPI_MODE_IDLE: begin
        if (!IN_BIT.overhead) begin
          out_next.data = idle_bit;
        end
      end
      default: out_next = IN_BIT;
    endcase
  end

  // Registered outbound bit
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      out_reg <= '0;
      mode_reg <= 3'h0;
    end else begin
      out_reg <= out_next;
      mode_reg <= 3'(mode);
    end
  end

  // Payload bit position counter, for software visibility
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      pos_reg <= 16'h0000;
    end else if (advance) begin
      pos_reg <= pos_reg + 16'h0001;
    end
  end

  assign PRDATA = prdata_reg;
  assign PREADY = pready_reg;
  assign PSLVERR = pslverr_reg;
  assign OUT_BIT = out_reg;
  assign MODE = mode_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_los_data: assert property (@(posedge CORE_CLK) disable iff (RST)
    (cfg_reg[3] && IN_BIT.valid) |=> (OUT_BIT.data == $past(pat_reg[4])))
    else $error("signal loss bit wrong");
  chk_los_mode: assert property (@(posedge CORE_CLK) disable iff (RST)
    cfg_reg[3] |=> (MODE == 3'h4))
    else $error("signal loss not top priority");
  chk_ais_ignored: assert property (@(posedge CORE_CLK) disable iff (RST)
    (cfg_reg[3] && cfg_reg[4]) |=> (MODE != 3'h2 && MODE != 3'h3))
    else $error("alarm not ignored");
  chk_unframed_ones: assert property (@(posedge CORE_CLK) disable iff (RST)
    (!cfg_reg[3] && cfg_reg[4] && pat_reg[7]) |=> OUT_BIT.data)
    else $error("unframed alarm not ones");
  chk_cbit_zero: assert property (@(posedge CORE_CLK) disable iff (RST)
    (!cfg_reg[3] && cfg_reg[4] && !pat_reg[7] && !pat_reg[6] && IN_BIT.cbit && IN_BIT.overhead)
    |=> !OUT_BIT.data)
    else $error("strict alarm C-bit not zero");
  chk_cbit_pass: assert property (@(posedge CORE_CLK) disable iff (RST)
    (!cfg_reg[3] && cfg_reg[4] && !pat_reg[7] && pat_reg[6] && IN_BIT.overhead)
    |=> (OUT_BIT.data == $past(IN_BIT.data)))
    else $error("relaxed alarm overhead altered");
  chk_alt_payload: assert property (@(posedge CORE_CLK) disable iff (RST)
    (mode == MPI_MODE_AIS_FRAMED && advance) |=> (OUT_BIT.data == !alt_bit))
    else $error("alarm payload not alternating");
  chk_idle_ignored: assert property (@(posedge CORE_CLK) disable iff (RST)
    (cfg_reg[5] && (cfg_reg[3] || cfg_reg[4])) |=> (MODE != 3'h1))
    else $error("idle not ignored");
  chk_data_pass: assert property (@(posedge CORE_CLK) disable iff (RST)
    (cfg_reg[5:3] == 3'h0) |=> (OUT_BIT == $past(IN_BIT)))
    else $error("data altered with no override");
  cov_los: cover property (@(posedge CORE_CLK) MODE == 3'h4);
  cov_ais_framed: cover property (@(posedge CORE_CLK) MODE == 3'h2);
  cov_ais_unframed: cover property (@(posedge CORE_CLK) MODE == 3'h3);
  cov_idle: cover property (@(posedge CORE_CLK) MODE == 3'h1);
endmodule : mpi_insert

/* File: tb/mpi_line_model.sv */
`timescale 1ns/10ps
module mpi_line_model
  import mpi_pkg::*;
(
  input wire logic clk,
  input wire mpi_bit_type line_bit,
  output logic [7:0] pay_hist,
  output logic last_oh,
  output logic last_cb
);
  // ----------------
  // Line receiver
  // ----------------
  // Sort each valid bit by slot class
  always_ff @(posedge clk) begin
    if (line_bit.valid && line_bit.cbit) begin
      last_cb <= line_bit.data;
    end else if (line_bit.valid && line_bit.overhead) begin
      last_oh <= line_bit.data;
    end else if (line_bit.valid) begin
      pay_hist <= {pay_hist[6:0], line_bit.data};
    end
  end
endmodule : mpi_line_model

/* File: tb/tb_top.sv */
`timescale 1ns/10ps
`include "mpi_regs.svh"
module tb_top
  import mpi_pkg::*;
;
  logic CORE_CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [15:0] PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic [2:0] MODE;
  mpi_bit_type IN_BIT, OUT_BIT;
  logic [7:0] hist, q;
  logic [31:0] rd;
  logic oh, cb, e;
  int num_errors = 0;
  int samples_checked = 0;
  // Cases: config, pattern, input data, check kind, payload, {oh,cb}, mode
  logic [7:0] t_cfg [7] = '{8'h38, 8'h08, 8'h30, 8'h10, 8'h10, 8'h20, 8'h00};
  logic [7:0] t_pat [7] = '{8'h00, 8'h10, 8'h00, 8'h40, 8'h80, 8'h0C, 8'h0C};
  logic t_d [7] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
  logic [1:0] t_kind [7] = '{2'd0, 2'd0, 2'd1, 2'd1, 2'd0, 2'd2, 2'd0};
  logic [7:0] t_exp [7] = '{8'h00, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'h00, 8'hFF};
  logic [1:0] t_oc [7] = '{2'b00, 2'b11, 2'b10, 2'b11, 2'b11, 2'b00, 2'b11};
  logic [2:0] t_mode [7] = '{MPI_MODE_LOS, MPI_MODE_LOS, MPI_MODE_AIS_FRAMED, MPI_MODE_AIS_FRAMED,
    MPI_MODE_AIS_UNFRAMED, MPI_MODE_IDLE, MPI_MODE_DATA};

  // Clock
  initial begin
    CORE_CLK = 1'b0;
    forever #2 CORE_CLK = ~CORE_CLK;
  end

  mpi_insert dut (.CORE_CLK(CORE_CLK), .RST(RST), .PADDR(PADDR), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PWDATA(PWDATA), .PSTRB(4'hF), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .IN_BIT(IN_BIT), .OUT_BIT(OUT_BIT), .MODE(MODE));

  mpi_line_model line (.clk(CORE_CLK), .line_bit(OUT_BIT), .pay_hist(hist), .last_oh(oh), .last_cb(cb));

  // ----------------
  // Tasks
  // ----------------
  task report_and_stop;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer, entered just after a rising edge; answer taken at the edge with PREADY high
  task apb(input logic [15:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    PSEL <= 1'b1;
    PADDR <= a;
    PWRITE <= w;
    PWDATA <= {24'h000000, d};
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    @(posedge CORE_CLK);
    while (PREADY !== 1'b1) begin
      n++;
      if (n > 20) begin
        num_errors++;
        $display("[FAIL] %0t no ready", $time);
        report_and_stop();
      end
      @(posedge CORE_CLK);
    end
    rd = PRDATA;
    q = rd[7:0];
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CORE_CLK);
  endtask : apb

  task send(input logic ov, input logic c, input logic d);
    IN_BIT <= '{valid: 1'b1, data: d, overhead: ov, cbit: c};
    @(posedge CORE_CLK);
  endtask : send

  // Overhead bit, C-bit, then payload, then let the pipe drain
  task run(input logic d);
    send(1'b1, 1'b0, d);
    send(1'b1, 1'b1, d);
    repeat (8) send(1'b0, 1'b0, d);
    repeat (3) @(posedge CORE_CLK);
  endtask : run

  // ----------------
  // Main sequence
  // ----------------
  initial begin
    RST = 1'b1;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 16'h0000;
    PWDATA = 32'h00000000;
    IN_BIT = '0;
    repeat (10) @(posedge CORE_CLK);
    RST <= 1'b0;
    @(posedge CORE_CLK);
    apb(`MPI_TX_LINE_CONFIG_ADDR, 1'b0, 8'h00);
    chk(q, `MPI_CFG_RESET);
    chk({7'h00, e}, 8'h00);
    apb(`MPI_TX_PATTERN_SELECT_ADDR, 1'b0, 8'h00);
    chk(q, `MPI_PAT_RESET);
    apb(`MPI_TX_PATTERN_SELECT_ADDR, 1'b1, 8'hFF);
    apb(`MPI_TX_PATTERN_SELECT_ADDR, 1'b0, 8'h00);
    chk(q, `MPI_PAT_WMASK);
    apb(16'h1200, 1'b0, 8'h00);
    chk({7'h00, e}, 8'h01);
    chk(q, 8'h00);
    $display("register test done");
    for (int i = 0; i < 7; i++) begin
      apb(`MPI_TX_PATTERN_SELECT_ADDR, 1'b1, t_pat[i]);
      apb(`MPI_TX_LINE_CONFIG_ADDR, 1'b1, t_cfg[i]);
      run(t_d[i]);
      chk({5'h00, MODE}, {5'h00, t_mode[i]});
      if (t_kind[i] == 2'd0) begin
        chk(hist, t_exp[i]);
      end
      if (t_kind[i] == 2'd1) begin
        chk({1'b0, hist[7:1] ^ hist[6:0]}, 8'h7F);
      end
      if (t_kind[i] == 2'd2) begin
        chk({2'b00, hist[5:0] ^ hist[7:2]}, 8'h3F);
      end
      if (t_kind[i] != 2'd2) begin
        chk({6'h00, oh, cb}, {6'h00, t_oc[i]});
      end
      $display("stream test %0d done", i);
    end
    apb(`MPI_FRAME_POS_ADDR, 1'b0, 8'h00);
    chk({5'h00, rd[18:16]}, {5'h00, 3'(MPI_MODE_DATA)});
    chk({7'h00, e}, 8'h00);
    report_and_stop();
  end
endmodule : tb_top
